// File: bench/apcc_audio_src.sv
// audio source model: bit, frame and master clocks and serial data
`timescale 1ns/10ps
module apcc_audio_src (
    output logic bclk,
    output logic lrclk,
    output logic mclk,
    output logic sdin
);
    logic level = 1'b0;
    initial begin
        bclk = 1'b0;
        lrclk = 1'b0;
        mclk = 1'b0;
        sdin = 1'b0;
    end
    // one frame of n bit clocks, two master clocks each; all clocks stop after it
    task automatic frame(input int n);
        #17;
        for (int i = 0; i < n; i++) begin
            lrclk = i < n / 2;
            sdin = level & lrclk; // ones only in the first half frame
            bclk = 1'b0;
            #100 mclk = ~mclk;
            #100 mclk = ~mclk;
            bclk = 1'b1;
            #100 mclk = ~mclk;
            #100 mclk = ~mclk;
        end
        bclk = 1'b0;
        sdin = ~level; // released line shows the inverse
    endtask
endmodule

// File: bench/apcc_check_sva.sv
// port assertions of the audio port checker
`timescale 1ns/10ps
module apcc_check (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire lrclk,
    input wire sample_valid,
    input wire clock_error,
    input wire irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [1:0] lr_q;
    logic [4:0] age_q;
    // cycles since the last frame edge, saturating
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lr_q <= 2'h0;
            age_q <= 5'h1f;
        end else begin
            lr_q <= {lr_q[0], lrclk};
            age_q <= (lr_q == 2'b01) ? 5'h00 : age_q + {4'h0, age_q != 5'h1f};
        end
    end
    // bus answers
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error flag outside access");
    a_rdata_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside read access");
    a_low_unmapped: assert property (psel && penable && paddr < 12'h098 |-> pslverr)
        else $error("unmapped access not flagged");
    a_map_ok: assert property (psel && penable && paddr inside {12'h098, 12'h09c,
        12'h0a0, 12'h0a4, 12'h0a8} |-> !pslverr) else $error("mapped access flagged");
    // clock supervision
    a_reset_err: assert property ($rose(presetn) |-> clock_error)
        else $error("bit clock good out of reset");
    a_err_cause: assert property ($changed(clock_error) |->
        age_q < 5'h10 || $past(psel && penable && pwrite)) else $error("error moved off edge");
    a_irq_cause: assert property ($rose(irq) |->
        age_q < 5'h10 || $past(psel && penable && pwrite)) else $error("irq rose off edge");
    a_valid_frame: assert property ($rose(lrclk) |-> ##[1:8] sample_valid)
        else $error("no sample pulse after frame edge");
    a_valid_once: assert property (sample_valid |=> !sample_valid [*8])
        else $error("sample pulse too long");
endmodule

// File: bench/testbench.sv
// self-checking bench of the audio port checker
`timescale 1ns/10ps
`include "apcc_regs.vh"
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, left_sample, right_sample, rd, d, m, lo, hi;
    logic pready, pslverr, bclk, lrclk, mclk, sdin, sample_valid, clock_error, irq, er;
    logic [11:0] ra[7] = '{12'h098, 12'h09c, 12'h0a0, 12'h0a4, 12'h0a8, 12'h0c8, 12'h0d0};
    logic [7:0] rv[7] = '{8'h11, 8'h04, 8'h02, 8'h00, 8'h11, 8'h00, 8'h00};
    logic [7:0] rm[7] = '{8'hff, 8'h1f, 8'h33, 8'hff, 8'h33, 8'h07, 8'h01};
    int tbl[8] = '{32, 32, 31, 64, 62, 66, 256, 257};
    int wl[4] = '{16, 20, 24, 32};
    int failures = 0;
    int comparisons = 0;
    int prv = 0, last = 0, run = 0, gthr = 1, bthr = 1, c, o, k, tol = 4;
    bit good = 0, ign = 0, mg = 0;
    logic [2:0] ist = 3'h0, ien = 3'h0;
    apcc_audio_port_check apcc_audio_port_check_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bclk(bclk), .lrclk(lrclk),
        .mclk(mclk), .sdin(sdin), .left_sample(left_sample), .right_sample(right_sample),
        .sample_valid(sample_valid), .clock_error(clock_error), .irq(irq));
    apcc_audio_src apcc_audio_src_i (.bclk(bclk), .lrclk(lrclk), .mclk(mclk), .sdin(sdin));
    always #25 pclk = ~pclk;
    task automatic conclude();
        $display("counts: comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    // one bus transfer: setup, then access until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            failures++;
            $display("[FAIL] t=%0t got %h expected %h", $time, pready, 1'b1);
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic x = 1'b0);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk(er, x);
    endtask
    // reference: frame count validity and good/bad runs
    task automatic mdl(input int n);
        bit v;
        v = n >= 32 && n <= 256 && n == prv;
        mg = (n * 2 >= 128 - tol && n * 2 <= 128 + tol) ||
            (n * 2 >= 256 - tol && n * 2 <= 256 + tol);
        prv = n;
        run = (v != good) ? run + 1 : 0;
        if (run == (good ? bthr : gthr) + 1) begin
            good = v;
            run = 0;
            ist |= good ? 3'h1 : 3'h5;
        end
    endtask
    task automatic frm(input int n);
        mdl(last);
        last = n;
        apcc_audio_src_i.frame(n);
        apb(1'b0, `APCC_ADDR_STAT, 32'h0);
        chk(rd[0], good);
        chk(clock_error, !good && !ign);
        chk(rd[2], !good && !ign);
        chk(rd[1], mg);
        chk(rd[12:3], prv);
        chk(irq, ien[2] && ist[2]);
    endtask
    initial begin
        void'($urandom(48225));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rchk(ra[i], {24'h0, rv[i]});
            d = $urandom;
            apb(1'b1, ra[i], d);
            rchk(ra[i], d & {24'h0, rm[i]});
            apb(1'b1, ra[i], {24'h0, rv[i]});
        end
        apb(1'b1, 12'h000, 32'hffff_ffff);
        rchk(12'h000, 32'h0, 1'b1);
        $display("test registers done");
        repeat (4) frm(64);
        apcc_audio_src_i.level = 1'b1;
        for (int i = 0; i < 16; i++) begin
            c = i % 3;
            m = ~(32'hffff_ffff >> wl[i / 4]);
            // ones in the first half; dsp right word keeps k leading ones
            k = (i < 12 ? 32 : 64) - wl[i / 4];
            k = k < 0 ? 0 : (k > wl[i / 4] ? wl[i / 4] : k);
            lo = i % 4 == 0 ? 32'h0 : m;
            hi = i % 4 == 0 ? m : (i % 4 == 1 ? ~(32'hffff_ffff >> k) : 32'h0);
            apb(1'b1, `APCC_ADDR_FMT, {26'h0, i[1:0], 2'h0, i[3:2]});
            apb(1'b1, `APCC_ADDR_DCP, {26'h0, c[1:0], 2'h0, 2'(2 - c)});
            repeat (2) frm(i < 12 ? 64 : 128);
            chk(left_sample, c == 0 ? 32'h0 : (c == 1 ? lo : hi));
            chk(right_sample, c == 2 ? 32'h0 : (c == 1 ? hi : lo));
        end
        // dsp, 16 bits, random slot offset: right word loses offset ones
        o = $urandom % 17;
        apb(1'b1, `APCC_ADDR_FMT, 32'h10);
        apb(1'b1, `APCC_ADDR_DCP, 32'h11);
        apb(1'b1, `APCC_ADDR_OFS, o);
        repeat (2) frm(64);
        chk(left_sample, 32'hffff_0000);
        chk(right_sample, ~(32'hffff_ffff >> (16 - o)));
        $display("test format and path done");
        gthr = $urandom % 4;
        bthr = $urandom % 4;
        apb(1'b1, `APCC_ADDR_BCQ, {24'h0, 4'(gthr), 4'(bthr)});
        tol = $urandom % 8;
        apb(1'b1, `APCC_ADDR_MCT, tol);
        repeat (30) frm(tbl[$urandom % 8]);
        ign = 1'b1;
        apb(1'b1, `APCC_ADDR_CTRL, 32'h1);
        repeat (5) frm(31);
        ign = 1'b0;
        apb(1'b1, `APCC_ADDR_CTRL, 32'h0);
        @(posedge pclk);
        chk(clock_error, 1'b1);
        $display("test thresholds done");
        apb(1'b1, `APCC_ADDR_IRQ_CLR, 32'h7);
        ist = 3'h0;
        ien = 3'h4;
        apb(1'b1, `APCC_ADDR_IRQ_EN, 32'h4);
        repeat (7) frm(64);
        repeat (5) frm(31);
        apb(1'b0, `APCC_ADDR_IRQ_STAT, 32'h0);
        chk(rd & 32'h5, {29'h0, ist});
        ien = 3'h0;
        apb(1'b1, `APCC_ADDR_IRQ_EN, 32'h0);
        apb(1'b1, `APCC_ADDR_IRQ_CLR, 32'h7);
        rchk(`APCC_ADDR_IRQ_STAT, 32'h0);
        chk(irq, 1'b0);
        $display("test interrupt done");
        conclude();
    end
endmodule
bind apcc_audio_port_check apcc_check apcc_check_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pslverr(pslverr), .lrclk(lrclk), .sample_valid(sample_valid),
    .clock_error(clock_error), .irq(irq));

// File: verilog/apcc_audio_port_check.v
// serial audio port format selection and bit/master clock supervision
//
// Summary of operation
// RQ1: count bit clocks per frame; valid if 32..256 and equal to previous frame
// RQ2: bit clock good after good-threshold plus one consecutive valid frames
// RQ3: bit clock bad after bad-threshold plus one consecutive invalid frames
// RQ4: master clock good when count matches any ratio within programmed tolerance
// RQ5: two-bit frame format: I2S, DSP, right-justified, left-justified
// RQ6: two-bit word length: 16, 20, 24 or 32 bits
// RQ7: sample starts offset bit clocks after frame start; zero means none
// RQ8: reset good threshold one, length 24 bits, format and offset zero
// RQ9: raise clock error on bad bit clock unless its check is ignored
// RQ10: each channel path selects mute, same-side or opposite channel data
// RQ11: good/bad state holds until opposite run completes; other frame restarts
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "apcc_regs.vh"

module apcc_audio_port_check (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire bclk,
    input wire lrclk,
    input wire mclk,
    input wire sdin,
    output reg [31:0] left_sample,
    output reg [31:0] right_sample,
    output reg sample_valid,
    output wire clock_error,
    output wire irq
);

    // ****************************************************************
    // register bus
    // ****************************************************************
    reg [7:0] bcq_q;
    reg [7:0] mct_q;
    reg [7:0] fmt_q;
    reg [7:0] ofs_q;
    reg [7:0] dcp_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_en_q;
    reg ignore_bclk_q;
    reg [31:0] ratio_q;
    reg bclk_good_q;
    reg mclk_good_q;
    reg [9:0] last_count_q;

    wire wr_en;
    wire rd_en;
    wire [2:0] evt;

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_known(paddr);

    // address decode, used by the error path
    function addr_known;
        input [11:0] a;
        begin
            case (a)
                `APCC_ADDR_BCQ, `APCC_ADDR_MCT, `APCC_ADDR_FMT, `APCC_ADDR_OFS,
                `APCC_ADDR_DCP, `APCC_ADDR_STAT, `APCC_ADDR_IRQ_STAT,
                `APCC_ADDR_IRQ_EN, `APCC_ADDR_IRQ_CLR, `APCC_ADDR_CTRL,
                `APCC_ADDR_RATIO: addr_known = 1'b1;
                default: addr_known = 1'b0;
            endcase
        end
    endfunction

    // register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // RQ8 reset field values
            bcq_q <= `APCC_BCQ_RST;
            mct_q <= `APCC_MCT_RST;
            fmt_q <= `APCC_FMT_RST;
            ofs_q <= `APCC_OFS_RST;
            dcp_q <= `APCC_DCP_RST;
            irq_en_q <= 3'h0;
            ignore_bclk_q <= 1'b0;
            ratio_q <= `APCC_RATIO_RST;
        end else if (wr_en) begin
            case (paddr)
                `APCC_ADDR_BCQ: bcq_q <= pwdata[7:0];
                `APCC_ADDR_MCT: mct_q <= {3'h0, pwdata[4:0]};
                `APCC_ADDR_FMT: fmt_q <= {2'h0, pwdata[5:4], 2'h0, pwdata[1:0]};
                `APCC_ADDR_OFS: ofs_q <= pwdata[7:0];
                `APCC_ADDR_DCP: dcp_q <= {2'h0, pwdata[5:4], 2'h0, pwdata[1:0]};
                `APCC_ADDR_IRQ_EN: irq_en_q <= pwdata[2:0];
                `APCC_ADDR_CTRL: ignore_bclk_q <= pwdata[0];
                `APCC_ADDR_RATIO: ratio_q <= pwdata;
                default: ;
            endcase
        end
    end

    // read mux
    always @* begin
        prdata = 32'h0;
        if (rd_en) begin
            case (paddr)
                `APCC_ADDR_BCQ: prdata = {24'h0, bcq_q};
                `APCC_ADDR_MCT: prdata = {24'h0, mct_q};
                `APCC_ADDR_FMT: prdata = {24'h0, fmt_q};
                `APCC_ADDR_OFS: prdata = {24'h0, ofs_q};
                `APCC_ADDR_DCP: prdata = {24'h0, dcp_q};
                `APCC_ADDR_STAT: prdata = {19'h0, last_count_q, clock_error,
                    mclk_good_q, bclk_good_q};
                `APCC_ADDR_IRQ_STAT: prdata = {29'h0, irq_stat_q};
                `APCC_ADDR_IRQ_EN: prdata = {29'h0, irq_en_q};
                `APCC_ADDR_CTRL: prdata = {31'h0, ignore_bclk_q};
                `APCC_ADDR_RATIO: prdata = ratio_q;
                default: prdata = 32'h0;
            endcase
        end
    end

    // sticky status, set wins over clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 3'h0;
        end else if (wr_en && paddr == `APCC_ADDR_IRQ_CLR) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | evt;
        end else begin
            irq_stat_q <= irq_stat_q | evt;
        end
    end

    assign irq = |(irq_stat_q & irq_en_q);

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    reg [3:0] sync1_q;
    reg [3:0] sync2_q;
    reg [2:0] prev_q;

    // two stages for each pin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            prev_q <= 3'h0;
        end else begin
            sync1_q <= {sdin, mclk, lrclk, bclk};
            sync2_q <= sync1_q;
            prev_q <= sync2_q[2:0];
        end
    end

    wire bclk_rise;
    wire mclk_rise;
    wire lr_edge;
    wire lr_rise;
    assign bclk_rise = sync2_q[0] & ~prev_q[0];
    assign lr_edge = sync2_q[1] ^ prev_q[1];
    assign lr_rise = sync2_q[1] & ~prev_q[1];
    assign mclk_rise = sync2_q[2] & ~prev_q[2];

    // ****************************************************************
    // bit clock qualification
    // ****************************************************************
    reg [9:0] bcnt_q;
    reg [10:0] mcnt_q;
    reg [3:0] run_q;
    reg frame_seen_q;
    wire [9:0] bcnt_tot;
    wire frame_ok;
    wire [3:0] run_lim;

    assign bcnt_tot = bclk_rise ? bcnt_q + 10'h1 : bcnt_q;
    // RQ1 range and repeat check
    assign frame_ok = frame_seen_q && bcnt_tot >= `APCC_BCLK_MIN &&
        bcnt_tot <= `APCC_BCLK_MAX && bcnt_tot == last_count_q;
    assign run_lim = bclk_good_q ? bcq_q[`APCC_BITCLK_BAD_COUNT_LSB+3:`APCC_BITCLK_BAD_COUNT_LSB] :
        bcq_q[`APCC_BITCLK_GOOD_COUNT_LSB+3:`APCC_BITCLK_GOOD_COUNT_LSB];

    // per-frame counting and persistence
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt_q <= 10'h0;
            last_count_q <= 10'h0;
            frame_seen_q <= 1'b0;
            run_q <= 4'h0;
            bclk_good_q <= 1'b0;
        end else if (lr_rise) begin
            // RQ1 count per frame
            bcnt_q <= 10'h0;
            last_count_q <= bcnt_tot;
            frame_seen_q <= 1'b1;
            if (frame_ok != bclk_good_q) begin
                // RQ2 RQ3 threshold plus one
                if (run_q == run_lim) begin
                    bclk_good_q <= frame_ok;
                    run_q <= 4'h0;
                end else begin
                    run_q <= run_q + 4'h1;
                end
            end else begin
                // RQ11 restart run
                run_q <= 4'h0;
            end
        end else if (bclk_rise && bcnt_q != 10'h3ff) begin
            bcnt_q <= bcnt_q + 10'h1;
        end
    end

    // RQ9 clock error gating
    assign clock_error = ~bclk_good_q & ~ignore_bclk_q;

    // ****************************************************************
    // master clock qualification
    // ****************************************************************
    wire [10:0] mcnt_tot;
    wire [10:0] tol;
    wire [10:0] ratio_a;
    wire [10:0] ratio_b;
    assign mcnt_tot = mclk_rise ? mcnt_q + 11'h1 : mcnt_q;
    assign tol = {6'h0, mct_q[4:0]};
    assign ratio_a = ratio_q[10:0];
    assign ratio_b = ratio_q[26:16];

    // ratio compare within tolerance
    function near;
        input [10:0] cnt;
        input [10:0] rval;
        input [10:0] t;
        begin
            near = ({1'b0, cnt} + {1'b0, t} >= {1'b0, rval}) && // one spare bit, no wrap
                ({1'b0, cnt} <= {1'b0, rval} + {1'b0, t});
        end
    endfunction

    // master clocks per frame
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcnt_q <= 11'h0;
            mclk_good_q <= 1'b0;
        end else if (lr_rise) begin
            mcnt_q <= 11'h0;
            // RQ4 any supported ratio
            mclk_good_q <= near(mcnt_tot, ratio_a, tol) | near(mcnt_tot, ratio_b, tol);
        end else if (mclk_rise && mcnt_q != 11'h7ff) begin
            mcnt_q <= mcnt_q + 11'h1;
        end
    end

    // events: bclk good change, mclk good change, bclk bad
    reg bgood_d1_q;
    reg mgood_d1_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bgood_d1_q <= 1'b0;
            mgood_d1_q <= 1'b0;
        end else begin
            bgood_d1_q <= bclk_good_q;
            mgood_d1_q <= mclk_good_q;
        end
    end
    assign evt = {bgood_d1_q & ~bclk_good_q, mgood_d1_q ^ mclk_good_q,
        bgood_d1_q ^ bclk_good_q};

    // ****************************************************************
    // serial data capture
    // ****************************************************************
    reg [8:0] slot_q;
    reg [31:0] shift_q;
    reg [31:0] lcap_q;
    reg [31:0] rcap_q;
    reg [5:0] got_q;
    reg chan_q;
    wire [5:0] wlen;
    wire [8:0] start;
    wire [1:0] fmt;

    assign fmt = fmt_q[`APCC_FMT_LSB+1:`APCC_FMT_LSB];

    // RQ6 word length decode
    assign wlen = (fmt_q[1:0] == 2'h0) ? 6'd16 : (fmt_q[1:0] == 2'h1) ? 6'd20 :
        (fmt_q[1:0] == 2'h2) ? 6'd24 : 6'd32;

    // RQ5 RQ7 first data bit of a half frame
    assign start = (fmt == `APCC_FMT_I2S) ? {1'b0, ofs_q} + 9'h1 :
        (fmt == `APCC_FMT_RTJ) ? {1'b0, ofs_q} +
        ((last_count_q[9:1] > {3'h0, wlen}) ? last_count_q[9:1] - {3'h0, wlen} : 9'h0) :
        {1'b0, ofs_q};

    // shift in on bit clock rise
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_q <= 9'h0;
            shift_q <= 32'h0;
            lcap_q <= 32'h0;
            rcap_q <= 32'h0;
            got_q <= 6'h0;
            chan_q <= 1'b0;
        end else if ((fmt == `APCC_FMT_DSP) ? lr_rise : lr_edge) begin
            // frame or half-frame start; DSP carries both words after one pulse
            slot_q <= 9'h0;
            got_q <= 6'h0;
            chan_q <= (fmt == `APCC_FMT_DSP) ? 1'b0 :
                (fmt == `APCC_FMT_I2S) ? sync2_q[1] : ~sync2_q[1];
        end else if (bclk_rise) begin
            slot_q <= slot_q + 9'h1;
            if (slot_q >= start && got_q < wlen) begin
                shift_q <= {shift_q[30:0], sync2_q[3]};
                got_q <= got_q + 6'h1;
                if (got_q + 6'h1 == wlen) begin
                    if (chan_q) begin
                        rcap_q <= ({shift_q[30:0], sync2_q[3]} << (6'd32 - wlen));
                    end else begin
                        lcap_q <= ({shift_q[30:0], sync2_q[3]} << (6'd32 - wlen));
                    end
                    if (fmt == `APCC_FMT_DSP && !chan_q) begin
                        chan_q <= 1'b1;
                        got_q <= 6'h0;
                        slot_q <= start; // right word follows with no gap
                    end
                end
            end
        end
    end

    // path select per channel
    function [31:0] route;
        input [1:0] sel;
        input [31:0] same;
        input [31:0] other;
        begin
            case (sel)
                `APCC_PATH_SAME: route = same;
                `APCC_PATH_CROSS: route = other;
                default: route = 32'h0;
            endcase
        end
    endfunction

    // output samples once per frame
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_sample <= 32'h0;
            right_sample <= 32'h0;
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= lr_rise;
            if (lr_rise) begin
                // RQ10 channel source select
                left_sample <= route(dcp_q[`APCC_LPATH_LSB+1:`APCC_LPATH_LSB], lcap_q, rcap_q);
                right_sample <= route(dcp_q[`APCC_RPATH_LSB+1:`APCC_RPATH_LSB], rcap_q, lcap_q);
            end
        end
    end

endmodule

// File: verilog/apcc_regs.vh
// register offsets, field positions, reset values and timing counts of the audio port checker
`ifndef APCC_REGS_VH
`define APCC_REGS_VH

// register indices (printed offsets) and byte addresses
`define APCC_IDX_BCQ 8'h26
`define APCC_IDX_MCT 8'h27
`define APCC_IDX_FMT 8'h28
`define APCC_IDX_OFS 8'h29
`define APCC_IDX_DCP 8'h2a
`define APCC_ADDR_BCQ 12'h098
`define APCC_ADDR_MCT 12'h09c
`define APCC_ADDR_FMT 12'h0a0
`define APCC_ADDR_OFS 12'h0a4
`define APCC_ADDR_DCP 12'h0a8
`define APCC_ADDR_STAT 12'h0c0
`define APCC_ADDR_IRQ_STAT 12'h0c4
`define APCC_ADDR_IRQ_EN 12'h0c8
`define APCC_ADDR_IRQ_CLR 12'h0cc
`define APCC_ADDR_CTRL 12'h0d0
`define APCC_ADDR_RATIO 12'h0d4

// field positions
`define APCC_BITCLK_GOOD_COUNT_LSB 4
`define APCC_BITCLK_BAD_COUNT_LSB 0
`define APCC_FMT_LSB 4
`define APCC_LEN_LSB 0
`define APCC_LPATH_LSB 4
`define APCC_RPATH_LSB 0

// reset values
`define APCC_BCQ_RST 8'h11
`define APCC_MCT_RST 8'h04
`define APCC_FMT_RST 8'h02
`define APCC_OFS_RST 8'h00
`define APCC_DCP_RST 8'h11
`define APCC_RATIO_RST 32'h0100_0080

// bit clock counts per frame that are acceptable
`define APCC_BCLK_MIN 10'h020
`define APCC_BCLK_MAX 10'h100

// frame formats
`define APCC_FMT_I2S 2'h0
`define APCC_FMT_DSP 2'h1
`define APCC_FMT_RTJ 2'h2
`define APCC_FMT_LTJ 2'h3

// path select codes
`define APCC_PATH_MUTE 2'h0
`define APCC_PATH_SAME 2'h1
`define APCC_PATH_CROSS 2'h2

`endif
